// [core/lips_top.sv]
// Live-insertion power sequencer top level
`default_nettype none
`include "lips_params.svh"

// Summary of operation
// RL1: Power-on reset: resets active, gates and enable off
// RL2: Permit low inhibits gates and driver enable
// RL3: Host reset forces resets; release restarts hold
// RL4: Supply select picks 5V, 3.3V or both
// RL5: Selected supplies, seated, permitted: ramp gates on
// RL6: Driver enable asserts with gate turn-on
// RL7: Card supplies good: start timer, flag good
// RL8: Hold expiry releases resets, signals valid
// RL9: Seat open or permit low: power off
// RL10: Host wires permit and reset from backplane
// RL11: Timer needs host reset and permit released
// RL12: Power-down drops gates to zero at once
// RL13: Hold counter restarts when start withdrawn
// RL14: Seat, host, rail and select inputs pass two flip-flop stages
module lips_top
    import lips_pkg::*;
#(
    parameter lips_cnt_t  HOLD_CYCLES      = lips_cnt_t'(`LIPS_HOLD_CYC),
    parameter lips_tick_t RAMP_STEP_CYCLES = lips_tick_t'(`LIPS_RAMP_STEP_CYC)
)
(
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_seat_detect_a_n,
    input  wire logic        i_seat_detect_b_n,
    input  wire logic        i_host_power_permit,
    input  wire logic        i_host_reset_n,
    input  wire logic [1:0]  i_supply_select,
    input  wire logic        i_bus_5v_ok,
    input  wire logic        i_bus_3v3_ok,
    input  wire logic        i_card_5v_ok,
    input  wire logic        i_card_3v3_ok,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output var  logic [31:0] o_rdata,
    output var  logic [7:0]  o_gate_drive_5v,
    output var  logic [7:0]  o_gate_drive_3v3,
    output var  logic        o_high_side_drive_en_n,
    output var  logic        o_card_supply_good,
    output var  logic        o_card_reset_n,
    output var  logic        o_card_reset,
    output var  logic        o_signals_valid_n
);

    // All state of the sequencer
    typedef struct packed {
        lips_state_e state;
        lips_tick_t  tick_cnt;
        lips_level_t level;
        logic        soft_off;
        logic        drive_en_n;
        logic        card_good;
        logic        rst_n;
        logic        rst;
        logic        valid_n;
        logic        timer_run;
        lips_word_t  rdata;
    } lips_top_s;

    lips_top_s st_q;
    lips_top_s st_d;

    lips_if    cif ();

    // Selected supplies all at or above trip
    function automatic logic supplies_ok(input logic [1:0] sel, input logic ok5, input logic ok3);
        logic res;
        res = 1'b0;
        case (sel)
            `LIPS_SEL_5V_ONLY:  res = ok5;       // RL4
            `LIPS_SEL_3V3_ONLY: res = ok3;       // RL4
            default:            res = ok5 & ok3; // RL4
        endcase
        return res;
    endfunction

    // Synchronised views of the pins
    logic       seated;
    logic       permit;
    logic       host_rel;
    logic [1:0] sel;
    logic       bus_ok;
    logic       card_ok;
    logic       power_ok;
    logic       ramp_tick;

    // Raw inputs into the synchroniser; one process gives the vector a single driver
    always_comb
    begin
        cif.raw[`LIPS_IN_SEAT_A]                   = i_seat_detect_a_n;
        cif.raw[`LIPS_IN_SEAT_B]                   = i_seat_detect_b_n;
        cif.raw[`LIPS_IN_PERMIT]                   = i_host_power_permit;
        cif.raw[`LIPS_IN_HRST_N]                   = i_host_reset_n;
        cif.raw[`LIPS_IN_BUS_5V]                   = i_bus_5v_ok;
        cif.raw[`LIPS_IN_BUS_3V3]                  = i_bus_3v3_ok;
        cif.raw[`LIPS_IN_CARD_5V]                  = i_card_5v_ok;
        cif.raw[`LIPS_IN_CARD_3V3]                 = i_card_3v3_ok;
        cif.raw[`LIPS_IN_SEL_MSB:`LIPS_IN_SEL_LSB] = i_supply_select;
    end

    // Two-stage synchronisers on every seat, host, rail and select input
    lips_sync u_sync (   // RL14
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .sif    (cif)
    );

    // Reset hold timer
    lips_timer #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_timer (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .tif    (cif)
    );

    // Qualified conditions from synchronised inputs
    // Seat switches pull low when closed, so both must read low
    assign seated   = ~cif.synced[`LIPS_IN_SEAT_A] & ~cif.synced[`LIPS_IN_SEAT_B];
    assign permit   = cif.synced[`LIPS_IN_PERMIT];
    assign host_rel = cif.synced[`LIPS_IN_HRST_N];
    assign sel      = cif.synced[`LIPS_IN_SEL_MSB:`LIPS_IN_SEL_LSB];
    assign bus_ok   = supplies_ok(sel, cif.synced[`LIPS_IN_BUS_5V], cif.synced[`LIPS_IN_BUS_3V3]);
    assign card_ok  = supplies_ok(sel, cif.synced[`LIPS_IN_CARD_5V], cif.synced[`LIPS_IN_CARD_3V3]);
    // Seated, permitted, bus good and not held off by software
    assign power_ok = seated & permit & bus_ok & ~st_q.soft_off; // RL5 RL9 RL2
    assign cif.timer_run = st_q.timer_run;

    // Ramp step divider: one-cycle tick per gate step
    // Runs freely outside OFF; the level saturates at full scale
    assign ramp_tick = (st_q.tick_cnt == RAMP_STEP_CYCLES - lips_tick_t'(1));

    // Sequencer next state, outputs and register port
    always_comb
    begin
        st_d       = st_q;
        st_d.rdata = '0;

        // Power-down wins over every state
        // A removal mid-hold restarts the whole sequence from OFF
        if (!power_ok)
        begin
            st_d.state = LIPS_OFF; // RL9 RL2
        end
        else
        begin
            case (st_q.state)
                LIPS_OFF:
                begin
                    st_d.state = LIPS_RAMP; // RL5
                end
                LIPS_RAMP:
                begin
                    if (card_ok)
                    begin
                        st_d.state = LIPS_HOLD; // RL7
                    end
                end
                LIPS_HOLD:
                begin
                    if (!card_ok)
                    begin
                        st_d.state = LIPS_RAMP;
                    end
                    else if (cif.timer_done)
                    begin
                        st_d.state = LIPS_READY; // RL8
                    end
                end
                LIPS_READY:
                begin
                    if (!card_ok)
                    begin
                        st_d.state = LIPS_RAMP;
                    end
                    else if (!host_rel)
                    begin
                        st_d.state = LIPS_HOLD; // RL3
                    end
                end
                default:
                begin
                    st_d.state = LIPS_OFF;
                end
            endcase
        end

        // Gate ramp level and its step divider
        // Gates drop to zero in the power-down step, no ramp down
        if (st_d.state == LIPS_OFF)
        begin
            st_d.level    = `LIPS_GATE_ZERO; // RL12
            st_d.tick_cnt = '0;
        end
        else
        begin
            if (ramp_tick)
            begin
                st_d.tick_cnt = '0;
            end
            else
            begin
                st_d.tick_cnt = st_q.tick_cnt + lips_tick_t'(1);
            end
            if (ramp_tick && st_q.level != `LIPS_GATE_MAX)
            begin
                st_d.level = st_q.level + `LIPS_GATE_ONE; // RL5
            end
        end

        // Driver enable follows gate turn-on
        st_d.drive_en_n = (st_d.state == LIPS_OFF); // RL6 RL2

        // Card supply good once card rails qualify
        st_d.card_good = (st_d.state == LIPS_HOLD) || (st_d.state == LIPS_READY); // RL7

        // Hold timer runs only with card good, host reset and permit released
        // Registered from the next state, so the timer runs from the HOLD entry cycle
        st_d.timer_run = (st_d.state == LIPS_HOLD) && card_ok && host_rel && permit; // RL11 RL3 RL13

        // Resets and signals valid follow hold completion
        st_d.rst_n   = (st_d.state == LIPS_READY) && host_rel; // RL8 RL3
        st_d.rst     = ~st_d.rst_n;  // RL8
        st_d.valid_n = ~st_d.rst_n;  // RL8

        // Register writes
        // Only bit 0 of the control word is kept
        if (i_wr && i_addr == `LIPS_REG_CTRL)
        begin
            st_d.soft_off = i_wdata[`LIPS_CTRL_SOFT_OFF];
        end

        // Register reads, data valid in the following cycle only
        if (i_rd)
        begin
            case (i_addr)
                `LIPS_REG_CTRL:
                begin
                    st_d.rdata[`LIPS_CTRL_SOFT_OFF] = st_q.soft_off;
                end
                `LIPS_REG_STAT:
                begin
                    st_d.rdata = lips_stat_s'{
                        zero      : '0,
                        inputs    : cif.synced,
                        level     : st_q.level,
                        soft_off  : st_q.soft_off,
                        drive_en  : ~st_q.drive_en_n,
                        card_good : st_q.card_good,
                        unused_z  : 1'b0,
                        state     : st_q.state
                    };
                end
                default:
                begin
                    st_d.rdata = '0;
                end
            endcase
        end
    end

    // State register; reset is the pre-charge supply coming up
    // Every reset value keeps the card unpowered and in reset
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            st_q.state      <= LIPS_OFF;        // RL1
            st_q.tick_cnt   <= '0;
            st_q.level      <= `LIPS_GATE_ZERO;  // RL1
            st_q.soft_off   <= `LIPS_CTRL_RST;
            st_q.drive_en_n <= 1'b1;            // RL1
            st_q.card_good  <= 1'b0;            // RL1
            st_q.rst_n      <= 1'b0;            // RL1
            st_q.rst        <= 1'b1;            // RL1
            st_q.valid_n    <= 1'b1;            // RL1
            st_q.timer_run  <= 1'b0;
            st_q.rdata      <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Outputs straight from flops
    // Both gate pins share one ramp register, so they never differ
    assign o_rdata                = st_q.rdata;
    assign o_gate_drive_5v        = st_q.level;
    assign o_gate_drive_3v3       = st_q.level;
    assign o_high_side_drive_en_n = st_q.drive_en_n;
    assign o_card_supply_good     = st_q.card_good;
    assign o_card_reset_n         = st_q.rst_n;
    assign o_card_reset           = st_q.rst;
    assign o_signals_valid_n      = st_q.valid_n;

endmodule

`default_nettype wire

// [inc/lips_params.svh]
// Constants for the live-insertion power sequencer
`ifndef LIPS_PARAMS_SVH
`define LIPS_PARAMS_SVH

// System clock rate
`define LIPS_CLK_HZ         40000000
// Gate ramp: nominal slew, full-scale gate voltage, ramp steps
`define LIPS_SLEW_V_PER_S   250
`define LIPS_GATE_FULL_MV   12000
`define LIPS_GATE_STEPS     255
`define LIPS_GATE_MAX       8'hFF
`define LIPS_GATE_ZERO      8'h00
`define LIPS_GATE_ONE       8'h01
// Cycles per ramp step, rounded down so the slew never falls below nominal
`define LIPS_RAMP_STEP_CYC  ((`LIPS_CLK_HZ / `LIPS_SLEW_V_PER_S) * `LIPS_GATE_FULL_MV / (1000 * `LIPS_GATE_STEPS))
// Reset hold time, in ms and in cycles
`define LIPS_HOLD_MS        100
`define LIPS_HOLD_CYC       (`LIPS_CLK_HZ / 1000 * `LIPS_HOLD_MS)

// Synchronised input vector layout
`define LIPS_NSYNC          10
`define LIPS_IN_SEAT_A      0
`define LIPS_IN_SEAT_B      1
`define LIPS_IN_PERMIT      2
`define LIPS_IN_HRST_N      3
`define LIPS_IN_BUS_5V      4
`define LIPS_IN_BUS_3V3     5
`define LIPS_IN_CARD_5V     6
`define LIPS_IN_CARD_3V3    7
`define LIPS_IN_SEL_LSB     8
`define LIPS_IN_SEL_MSB     9
// Synchroniser reset value: seat switches open, host reset asserted
`define LIPS_SYNC_RST       10'h003

// Supply select encodings (any other value selects both)
`define LIPS_SEL_5V_ONLY    2'h0
`define LIPS_SEL_3V3_ONLY   2'h1

// Register map and control fields
`define LIPS_REG_CTRL       8'h00
`define LIPS_REG_STAT       8'h04
`define LIPS_CTRL_SOFT_OFF  0
`define LIPS_CTRL_RST       1'b0

`endif

// [inc/lips_pkg.sv]
// Types for the live-insertion power sequencer
`default_nettype none
`include "lips_params.svh"

package lips_pkg;

    typedef logic [31:0] lips_cnt_t;
    typedef logic [15:0] lips_tick_t;
    typedef logic [7:0]  lips_level_t;
    typedef logic [7:0]  lips_addr_t;
    typedef logic [31:0] lips_word_t;
    typedef logic [`LIPS_NSYNC-1:0] lips_in_t;

    // Sequencer states
    typedef enum logic [1:0] {
        LIPS_OFF   = 2'b00,
        LIPS_RAMP  = 2'b01,
        LIPS_HOLD  = 2'b10,
        LIPS_READY = 2'b11
    } lips_state_e;

    // Status register layout, bit 0 upward from the right
    typedef struct packed {
        logic [7:0]  zero;
        lips_in_t    inputs;
        lips_level_t level;
        logic        soft_off;
        logic        drive_en;
        logic        card_good;
        logic        unused_z;
        lips_state_e state;
    } lips_stat_s;

endpackage

`default_nettype wire

// [inc/lips_if.sv]
// Carrier between the sequencer and its synchroniser and hold timer
`default_nettype none
`include "lips_params.svh"

interface lips_if;
    logic [`LIPS_NSYNC-1:0] raw;
    logic [`LIPS_NSYNC-1:0] synced;
    logic                   timer_run;
    logic                   timer_done;

    modport sync_mp  (input raw, output synced);
    modport timer_mp (input timer_run, output timer_done);
    modport ctrl_mp  (output raw, input synced, output timer_run, input timer_done);
endinterface

`default_nettype wire

// [core/lips_sync.sv]
// Two-stage synchroniser for all external inputs except the register bus
`default_nettype none
`include "lips_params.svh"

module lips_sync
    import lips_pkg::*;
(
    input  wire logic  i_clk,
    input  wire logic  i_rstn,
    lips_if.sync_mp    sif
);

    typedef struct packed {
        lips_in_t s1;
        lips_in_t s2;
    } lips_sync_s;

    lips_sync_s st_q;
    lips_sync_s st_d;

    // Stage one feeds stage two only
    always_comb
    begin
        st_d    = st_q;
        st_d.s1 = sif.raw;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            st_q <= {`LIPS_SYNC_RST, `LIPS_SYNC_RST};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign sif.synced = st_q.s2;

endmodule

`default_nettype wire

// [core/lips_timer.sv]
// Reset hold timer: counts while run is high, restarts when it drops
`default_nettype none
`include "lips_params.svh"

module lips_timer
    import lips_pkg::*;
#(
    parameter lips_cnt_t HOLD_CYCLES = lips_cnt_t'(`LIPS_HOLD_CYC)
)
(
    input  wire logic  i_clk,
    input  wire logic  i_rstn,
    lips_if.timer_mp   tif
);

    typedef struct packed {
        lips_cnt_t cnt;
        logic      done;
    } lips_timer_s;

    lips_timer_s st_q;
    lips_timer_s st_d;

    // Count up to the terminal value, clear on any withdrawal
    always_comb
    begin
        st_d = st_q;
        if (!tif.timer_run)
        begin
            st_d.cnt  = '0; // RL13
            st_d.done = 1'b0;
        end
        else if (st_q.cnt == HOLD_CYCLES - lips_cnt_t'(1))
        begin
            st_d.done = 1'b1; // RL13
        end
        else
        begin
            st_d.cnt = st_q.cnt + lips_cnt_t'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign tif.timer_done = st_q.done;

endmodule

`default_nettype wire

// [tb/lips_top_sva.sv]
// Port-level checker for the live-insertion sequencer
`default_nettype none

module lips_top_sva
    import lips_pkg::*;
#(
    parameter lips_cnt_t HOLD_CYCLES = 32'h0000_0014
)
(
    input wire logic        i_clk,
    input wire logic        i_rstn,
    input wire logic        i_seat_detect_a_n,
    input wire logic        i_seat_detect_b_n,
    input wire logic        i_host_power_permit,
    input wire logic        i_host_reset_n,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic [7:0]  o_gate_drive_5v,
    input wire logic [7:0]  o_gate_drive_3v3,
    input wire logic        o_high_side_drive_en_n,
    input wire logic        o_card_supply_good,
    input wire logic        o_card_reset_n,
    input wire logic        o_card_reset,
    input wire logic        o_signals_valid_n
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [31:0] good_cnt_q;

    // Raw cycles with card good and host lines released; leads the synchronised view
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            good_cnt_q <= 32'h0000_0000;
        else if (o_card_supply_good && i_host_reset_n && i_host_power_permit)
            good_cnt_q <= good_cnt_q + 32'h0000_0001;
        else
            good_cnt_q <= 32'h0000_0000;
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    // Power removed and card held in reset
    sequence power_down_s;
        o_high_side_drive_en_n && (o_gate_drive_5v == 8'h00) && !o_card_reset_n;
    endsequence

    // Card held in reset and not flagged ready
    sequence reset_held_s;
        !o_card_reset_n && o_signals_valid_n;
    endsequence

    permit_off_a: assert property (!i_host_power_permit |-> ##[1:4] power_down_s)
        else $error("power stayed on without permit");
    seat_off_a: assert property ((i_seat_detect_a_n || i_seat_detect_b_n) |-> ##[1:4] power_down_s)
        else $error("power stayed on with a seat switch open");
    host_reset_a: assert property (!i_host_reset_n |-> ##[1:4] reset_held_s)
        else $error("host reset did not reach the card");
    gate_equal_a: assert property (o_gate_drive_5v == o_gate_drive_3v3)
        else $error("gate drives differ");
    gate_off_a: assert property (o_high_side_drive_en_n |-> (o_gate_drive_5v == 8'h00))
        else $error("gate drive without driver enable");
    ramp_step_a: assert property ($changed(o_gate_drive_5v) |->
        (o_gate_drive_5v == $past(o_gate_drive_5v) + 8'h01) || (o_gate_drive_5v == 8'h00))
        else $error("gate ramp jumped");
    hold_time_a: assert property ($rose(o_card_reset_n) |-> (good_cnt_q >= HOLD_CYCLES))
        else $error("reset released before hold time");
    card_good_a: assert property (!o_card_supply_good |-> reset_held_s)
        else $error("reset released without card supply good");
    valid_pair_a: assert property (o_signals_valid_n != o_card_reset_n)
        else $error("signals valid disagrees with reset");
    reset_pair_a: assert property (o_card_reset != o_card_reset_n)
        else $error("reset outputs not complementary");
    rdata_idle_a: assert property (!$past(i_rd) |-> (o_rdata == 32'h0000_0000))
        else $error("read data outside its cycle");
endmodule

bind lips_top lips_top_sva #(.HOLD_CYCLES(HOLD_CYCLES)) u_sva (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_seat_detect_a_n(i_seat_detect_a_n),
    .i_seat_detect_b_n(i_seat_detect_b_n), .i_host_power_permit(i_host_power_permit),
    .i_host_reset_n(i_host_reset_n), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_gate_drive_5v(o_gate_drive_5v), .o_gate_drive_3v3(o_gate_drive_3v3),
    .o_high_side_drive_en_n(o_high_side_drive_en_n), .o_card_supply_good(o_card_supply_good),
    .o_card_reset_n(o_card_reset_n), .o_card_reset(o_card_reset), .o_signals_valid_n(o_signals_valid_n)
);

`default_nettype wire

// [tb/lips_card_model.sv]
// Backplane wiring and card rail model facing the sequencer
`default_nettype none

module lips_card_model
(
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    input  wire logic [7:0] i_gate_drive_5v,
    input  wire logic [7:0] i_gate_drive_3v3,
    input  wire logic       i_high_side_drive_en_n,
    input  wire logic       i_rail_fail,
    input  wire logic       i_backplane_insert_permit,
    input  wire logic       i_backplane_reset_n,
    output var  logic       o_card_5v_ok,
    output var  logic       o_card_3v3_ok,
    output var  logic       o_host_power_permit,
    output var  logic       o_host_reset_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // Host inputs wired straight from the backplane lines
    assign o_host_power_permit = i_backplane_insert_permit;
    assign o_host_reset_n      = i_backplane_reset_n;

    // Rails good only with the FET fully on; a dropped gate kills them next cycle
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_card_5v_ok  <= 1'b0;
            o_card_3v3_ok <= 1'b0;
        end
        else
        begin
            o_card_5v_ok  <= (i_gate_drive_5v == 8'hFF) && !i_high_side_drive_en_n && !i_rail_fail;
            o_card_3v3_ok <= (i_gate_drive_3v3 == 8'hFF) && !i_high_side_drive_en_n && !i_rail_fail;
        end
    end
endmodule

`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the live-insertion sequencer
`default_nettype none

module tb_top
    import lips_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam lips_cnt_t  HOLD = 32'h0000_0014;
    localparam lips_tick_t STEP = 16'h0002;

    typedef struct packed { logic [1:0] sel; logic b5; logic b3; logic on; } lips_row_s;
    // Supply select, bus rails, expected power state
    lips_row_s rows [8] = '{'{2'h0, 1'b1, 1'b0, 1'b1}, '{2'h0, 1'b0, 1'b1, 1'b0},
                            '{2'h1, 1'b0, 1'b1, 1'b1}, '{2'h1, 1'b1, 1'b0, 1'b0},
                            '{2'h2, 1'b1, 1'b1, 1'b1}, '{2'h2, 1'b1, 1'b0, 1'b0},
                            '{2'h3, 1'b1, 1'b1, 1'b1}, '{2'h3, 1'b0, 1'b1, 1'b0}};

    logic i_clk = 1'b0, i_rstn, seat_a_n, seat_b_n, permit, hrst_n, bus5, bus3, card5, card3;
    logic wr, rd, drv_n, good, rst_n, rst, valid_n, bp_permit, bp_reset_n, rail_fail;
    logic [1:0] sel;
    lips_addr_t addr;
    lips_word_t wdata, rdata;
    lips_level_t gate5, gate3;
    int err_count = 0, total_checks = 0, cyc = 0, n, i;

    lips_top #(.HOLD_CYCLES(HOLD), .RAMP_STEP_CYCLES(STEP)) dut (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_seat_detect_a_n(seat_a_n), .i_seat_detect_b_n(seat_b_n),
        .i_host_power_permit(permit), .i_host_reset_n(hrst_n), .i_supply_select(sel),
        .i_bus_5v_ok(bus5), .i_bus_3v3_ok(bus3), .i_card_5v_ok(card5), .i_card_3v3_ok(card3),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_gate_drive_5v(gate5), .o_gate_drive_3v3(gate3), .o_high_side_drive_en_n(drv_n),
        .o_card_supply_good(good), .o_card_reset_n(rst_n), .o_card_reset(rst), .o_signals_valid_n(valid_n));

    lips_card_model u_model (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_gate_drive_5v(gate5), .i_gate_drive_3v3(gate3),
        .i_high_side_drive_en_n(drv_n), .i_rail_fail(rail_fail), .i_backplane_insert_permit(bp_permit),
        .i_backplane_reset_n(bp_reset_n), .o_card_5v_ok(card5), .o_card_3v3_ok(card3),
        .o_host_power_permit(permit), .o_host_reset_n(hrst_n));

    // 40 MHz clock
    always #12.5 i_clk = ~i_clk;

    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Hang guard
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            test_done();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // Everything off and card held in reset
    task automatic chk_off();
        check(gate5, 8'h00);
        check(drv_n, 1'b1);
        check(good, 1'b0);
        check(rst_n, 1'b0);
        check(valid_n, 1'b1);
        check(gate3, 8'h00);
        check(rst, 1'b1);
    endtask

    // Bounded wait: 0 driver enable, 1 gate full, 2 card good, 3 reset released
    task automatic wait_for(input int which, input logic want);
        logic v;
        n = 0;
        v = ~want;
        while (v !== want && n < 3000)
        begin
            @(posedge i_clk);
            #1;
            n++;
            case (which)
                0: v = drv_n;
                1: v = (gate5 == 8'hFF);
                2: v = good;
                default: v = rst_n;
            endcase
        end
        check(v, want);
    endtask

    task automatic bus_wr(input lips_addr_t a, input lips_word_t d);
        @(posedge i_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask

    task automatic bus_rd(input lips_addr_t a, input lips_word_t exp);
        @(posedge i_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge i_clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
        @(posedge i_clk);
        #1;
        check(rdata, 32'h0000_0000);
    endtask

    initial
    begin
        {i_rstn, wr, rd, rail_fail, bp_permit, bp_reset_n, bus5, bus3, sel} = 10'h000;
        {seat_a_n, seat_b_n, addr, wdata} = 42'h300_0000_0000;
        repeat (10) @(posedge i_clk);
        #1;
        chk_off();
        @(posedge i_clk);
        i_rstn <= 1'b1;
        seat_a_n <= 1'b0;
        seat_b_n <= 1'b0;
        bp_permit <= 1'b1;
        bp_reset_n <= 1'b1;
        // Supply select table
        for (i = 0; i < 8; i++)
        begin
            @(posedge i_clk);
            sel <= rows[i].sel;
            bus5 <= rows[i].b5;
            bus3 <= rows[i].b3;
            repeat (8) @(posedge i_clk);
            #1;
            check(drv_n, !rows[i].on);
            check(gate5 == 8'h00, !rows[i].on);
        end
        // Full power-up and status read
        @(posedge i_clk);
        sel <= 2'h2;
        bus5 <= 1'b1;
        bus3 <= 1'b1;
        wait_for(0, 1'b0);
        wait_for(1, 1'b1);
        check(n >= 254 * STEP && n <= 256 * STEP, 1'b1);
        wait_for(2, 1'b1);
        check(rst_n, 1'b0);
        wait_for(3, 1'b1);
        check(n >= HOLD && n <= HOLD + 4, 1'b1);
        check(valid_n, 1'b0);
        bus_rd(8'h04, 32'h00BF_3FDB);
        bus_rd(8'h08, 32'h0000_0000);
        // Host reset while ready: power stays, hold restarts
        @(posedge i_clk);
        bp_reset_n <= 1'b0;
        wait_for(3, 1'b0);
        check(n <= 4, 1'b1);
        repeat (HOLD + 10) @(posedge i_clk);
        #1;
        check(rst_n, 1'b0);
        check(drv_n, 1'b0);
        check(gate5, 8'hFF);
        @(posedge i_clk);
        bp_reset_n <= 1'b1;
        wait_for(3, 1'b1);
        check(n >= HOLD && n <= HOLD + 4, 1'b1);
        // Card rail loss: reset, gates kept
        @(posedge i_clk);
        rail_fail <= 1'b1;
        wait_for(2, 1'b0);
        check(rst_n, 1'b0);
        check(gate5, 8'hFF);
        @(posedge i_clk);
        rail_fail <= 1'b0;
        wait_for(3, 1'b1);
        check(n >= HOLD && n <= HOLD + 8, 1'b1);
        // Soft off, with a write elsewhere ignored
        bus_wr(8'h08, 32'h0000_0001);
        repeat (6) @(posedge i_clk);
        #1;
        check(drv_n, 1'b0);
        bus_wr(8'h00, 32'h0000_0001);
        wait_for(0, 1'b1);
        chk_off();
        bus_rd(8'h00, 32'h0000_0001);
        bus_wr(8'h00, 32'h0000_0000);
        wait_for(3, 1'b1);
        // Permit withdrawn, then seat switch opened
        @(posedge i_clk);
        bp_permit <= 1'b0;
        wait_for(0, 1'b1);
        chk_off();
        @(posedge i_clk);
        bp_permit <= 1'b1;
        wait_for(3, 1'b1);
        @(posedge i_clk);
        seat_b_n <= 1'b1;
        wait_for(0, 1'b1);
        chk_off();
        @(posedge i_clk);
        seat_b_n <= 1'b0;
        // Reset in mid-ramp
        repeat (20) @(posedge i_clk);
        i_rstn <= 1'b0;
        @(posedge i_clk);
        #1;
        chk_off();
        test_done();
    end
endmodule

`default_nettype wire
